// *** verilog/ladc_defs.svh ***
// Constants of the analog dimming and calibration block.
// Assumes a 50 MHz clock and a 32-bit classic Wishbone slave port.
`ifndef LADC_DEFS_SVH
`define LADC_DEFS_SVH
`define LADC_ADR_CTRL0 8'h00
`define LADC_ADR_CTRL1 8'h04
`define LADC_ADR_CAL0 8'h08
`define LADC_ADR_CAL1 8'h0C
`define LADC_ADR_STAT 8'h10
`define LADC_ADR_IRQ_STAT 8'h14
`define LADC_ADR_IRQ_MASK 8'h18
`define LADC_BIT_REF_SEL 8
`define LADC_BIT_PWM 9
`define LADC_BIT_CAL_EN 10
`define LADC_BIT_CAL_START 11
`define LADC_CTRL_RST 12'h000
`define LADC_CAL_RST 8'h00
`define LADC_IRQ_RST 4'h0
`define LADC_CAL_TIME_US 200
`define LADC_CLK_MHZ 50
`endif

// *** verilog/ladc_pkg.sv ***
// Types shared by the dimming block and its channel module.
// Assumes the constants header is included where offsets are needed.
package ladc_pkg;
    typedef enum logic [1:0] {
        ST_STOP = 2'b00,
        ST_SOFT = 2'b01,
        ST_RUN = 2'b10
    } ladc_state_e;
    typedef struct packed {
        logic [7:0] level;
        logic ref_ext;
        logic pwm_bit;
        logic cal_en;
    } ladc_cfg_s;
    typedef struct packed {
        logic pulse_in;
        logic ext_low;
        logic ext_high;
        logic over_range;
        logic ss_released;
        logic [7:0] cal_measured;
    } ladc_pins_s;
    typedef struct packed {
        logic switch_en;
        logic gate_en;
        logic ref_ext;
        logic soft_start;
        logic fccm;
        logic stretch;
        logic cal_run;
        logic cal_done;
        logic [7:0] dac_level;
        logic [7:0] cal_offset;
    } ladc_out_s;
endpackage

// *** verilog/ladc_channel.sv ***
// One channel: start/stop sequencing, reference routing and calibration.
// Assumes comparator flags on pins are already synchronous to i_clk.
module ladc_channel #(
    parameter int CAL_CYCLES = 10000
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire ladc_pkg::ladc_cfg_s i_cfg,
    input wire logic i_cal_start,
    input wire logic [7:0] i_cal_wr_value,
    input wire logic i_fallback,
    input wire logic i_enable_uv,
    input wire ladc_pkg::ladc_pins_s i_pins,
    output ladc_pkg::ladc_out_s o_out,
    output logic o_stop_evt,
    output logic o_done_evt
);
    localparam int CW = $clog2(CAL_CYCLES + 1);
    ladc_pkg::ladc_state_e state_reg, state_next;
    ladc_pkg::ladc_out_s out_reg, out_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [7:0] result_reg, result_next;
    logic stop_reg, stop_next, done_evt_reg, done_evt_next;
    logic use_ext, zero_req, restart_ok, gate, active, accept;

    always_comb begin
        // fallback forces the external pin as reference.
        use_ext = i_fallback | i_cfg.ref_ext;
        // external low stop and high restart
        zero_req = use_ext ? i_pins.ext_low : (i_cfg.level == 8'h00);
        restart_ok = use_ext ? i_pins.ext_high : (i_cfg.level != 8'h00);
        gate = i_fallback ? (i_pins.pulse_in & i_enable_uv)
                          : (i_pins.pulse_in | i_cfg.pwm_bit);
        state_next = state_reg;
        unique case (state_reg)
            ladc_pkg::ST_STOP: if (restart_ok && !zero_req) begin
                state_next = ladc_pkg::ST_SOFT;
            end
            ladc_pkg::ST_SOFT: if (zero_req) begin
                state_next = ladc_pkg::ST_STOP;
            end else if (i_pins.ss_released) begin
                state_next = ladc_pkg::ST_RUN;
            end
            ladc_pkg::ST_RUN: if (zero_req) begin
                state_next = ladc_pkg::ST_STOP;
            end
            default: state_next = ladc_pkg::ST_STOP;
        endcase
        active = state_next != ladc_pkg::ST_STOP;
        stop_next = !active && state_reg != ladc_pkg::ST_STOP;
        accept = i_cal_start & i_cfg.cal_en & !out_reg.cal_run;
        out_next = out_reg;
        cnt_next = cnt_reg;
        result_next = result_reg;
        done_evt_next = 1'b0;
        if (accept) begin
            // routine runs for the set time
            out_next.cal_run = 1'b1;
            cnt_next = CW'(CAL_CYCLES - 1);
            out_next.cal_done = 1'b0;
        end else if (out_reg.cal_run) begin
            if (!i_cfg.cal_en) begin
                out_next.cal_run = 1'b0;
            end else if (cnt_reg == '0) begin
                out_next.cal_run = 1'b0;
                out_next.cal_done = 1'b1;
                done_evt_next = 1'b1;
                result_next = i_pins.cal_measured;
            end else begin
                cnt_next = cnt_reg - CW'(1);
            end
        end
        out_next.cal_offset = i_cfg.cal_en ? result_next : i_cal_wr_value;
        out_next.ref_ext = use_ext;
        // register level drives the internal reference
        out_next.dac_level = i_cfg.level;
        out_next.gate_en = gate;
        out_next.switch_en = active & gate;
        out_next.soft_start = state_next == ladc_pkg::ST_SOFT;
        out_next.fccm = active & (!(use_ext & i_pins.over_range)
                                  | i_pins.ss_released);
        out_next.stretch = active & use_ext & i_pins.over_range
                           & !i_pins.ss_released;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= ladc_pkg::ST_STOP;
            out_reg <= '0;
            cnt_reg <= '0;
            result_reg <= 8'h00;
            stop_reg <= 1'b0;
            done_evt_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            out_reg <= out_next;
            cnt_reg <= cnt_next;
            result_reg <= result_next;
            stop_reg <= stop_next;
            done_evt_reg <= done_evt_next;
        end
    end

    assign o_out = out_reg;
    assign o_stop_evt = stop_reg;
    assign o_done_evt = done_evt_reg;
endmodule // ladc_channel

// *** verilog/ladc_top.sv ***
// Two-channel analog dimming control with a Wishbone register port.
// Assumes synchronous pins and a classic single-cycle Wishbone master.
`include "ladc_defs.svh"
module ladc_top #(
    parameter int CAL_CYCLES = `LADC_CAL_TIME_US * `LADC_CLK_MHZ
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_fallback_request_pin,
    input wire logic i_enable_undervoltage_pin,
    input wire ladc_pkg::ladc_pins_s [1:0] i_chan_pins,
    output ladc_pkg::ladc_out_s [1:0] o_chan,
    output logic o_fallback,
    output logic o_irq
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [11:0] ctrl_reg [2];
    logic [11:0] ctrl_next [2];
    logic [7:0] calw_reg [2];
    logic [7:0] calw_next [2];
    logic [1:0] start_reg, start_next;
    logic [3:0] irq_stat_reg, irq_stat_next;
    logic [3:0] irq_mask_reg, irq_mask_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic irq_reg, irq_next;
    logic fb_reg, fb_next;
    logic req, wr;
    wire logic [1:0] stop_evt, done_evt;
    wire ladc_pkg::ladc_cfg_s [1:0] cfg;
    wire ladc_pkg::ladc_out_s [1:0] chan_out;

    assign req = i_wb_cyc & i_wb_stb & !ack_reg;
    assign wr = req & i_wb_we;

    // ----------------------------------------------------------------
    // Bus slave and registers
    // ----------------------------------------------------------------
    always_comb begin
        ack_next = req;
        rdat_next = 32'h0000_0000;
        start_next = 2'b00;
        irq_mask_next = irq_mask_reg;
        // Set wins over clear: pending events are ORed after the clear.
        irq_stat_next = irq_stat_reg;
        for (int c = 0; c < 2; c++) begin
            ctrl_next[c] = ctrl_reg[c];
            calw_next[c] = calw_reg[c];
        end
        if (req) begin
            unique case (i_wb_adr)
                `LADC_ADR_CTRL0, `LADC_ADR_CTRL1: begin
                    for (int c = 0; c < 2; c++) begin
                        if (i_wb_adr[2] == c[0]) begin
                            rdat_next = {20'h00000, 1'b0, ctrl_reg[c][10:0]};
                            if (wr && i_wb_sel[0]) begin
                                ctrl_next[c][7:0] = i_wb_dat[7:0];
                            end
                            if (wr && i_wb_sel[1]) begin
                                ctrl_next[c][10:8] = i_wb_dat[10:8];
                                start_next[c] =
                                    i_wb_dat[`LADC_BIT_CAL_START];
                            end
                        end
                    end
                end
                `LADC_ADR_CAL0, `LADC_ADR_CAL1: begin
                    for (int c = 0; c < 2; c++) begin
                        if (i_wb_adr[2] == c[0]) begin
                            // read shows the value in use
                            rdat_next = {24'h000000, chan_out[c].cal_offset};
                            if (wr && i_wb_sel[0]) begin
                                calw_next[c] = i_wb_dat[7:0];
                            end
                        end
                    end
                end
                `LADC_ADR_STAT: begin
                    rdat_next = {16'h0000,
                                 3'b000, fb_reg,
                                 chan_out[1].cal_done, chan_out[1].cal_run,
                                 chan_out[1].soft_start,
                                 chan_out[1].switch_en,
                                 4'h0,
                                 chan_out[0].cal_done, chan_out[0].cal_run,
                                 chan_out[0].soft_start,
                                 chan_out[0].switch_en};
                end
                `LADC_ADR_IRQ_STAT: begin
                    rdat_next = {28'h0000000, irq_stat_reg};
                    if (wr && i_wb_sel[0]) begin
                        irq_stat_next = irq_stat_reg & ~i_wb_dat[3:0];
                    end
                end
                `LADC_ADR_IRQ_MASK: begin
                    rdat_next = {28'h0000000, irq_mask_reg};
                    if (wr && i_wb_sel[0]) begin
                        irq_mask_next = i_wb_dat[3:0];
                    end
                end
                default: rdat_next = 32'h0000_0000;
            endcase
        end
        irq_stat_next = irq_stat_next | {stop_evt[1], done_evt[1],
                                         stop_evt[0], done_evt[0]};
        irq_next = |(irq_stat_next & irq_mask_next);
        // fallback state follows the request pin
        fb_next = i_fallback_request_pin;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int c = 0; c < 2; c++) begin
                ctrl_reg[c] <= `LADC_CTRL_RST;
                calw_reg[c] <= `LADC_CAL_RST;
            end
            start_reg <= 2'b00;
            irq_stat_reg <= `LADC_IRQ_RST;
            irq_mask_reg <= `LADC_IRQ_RST;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
            fb_reg <= 1'b0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                ctrl_reg[c] <= ctrl_next[c];
                calw_reg[c] <= calw_next[c];
            end
            start_reg <= start_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            irq_reg <= irq_next;
            fb_reg <= fb_next;
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;
    assign o_irq = irq_reg;
    assign o_fallback = fb_reg;
    assign o_chan = chan_out;

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    // The start strobe is a one-cycle pulse; a start written while the
    // routine runs is dropped rather than queued.
    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign cfg[g].level = ctrl_reg[g][7:0];
        assign cfg[g].ref_ext = ctrl_reg[g][`LADC_BIT_REF_SEL];
        assign cfg[g].pwm_bit = ctrl_reg[g][`LADC_BIT_PWM];
        assign cfg[g].cal_en = ctrl_reg[g][`LADC_BIT_CAL_EN];

        ladc_channel #(
            .CAL_CYCLES(CAL_CYCLES)
        ) u_ch (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_cfg(cfg[g]),
            .i_cal_start(start_reg[g]),
            .i_cal_wr_value(calw_reg[g]),
            .i_fallback(fb_reg),
            .i_enable_uv(i_enable_undervoltage_pin),
            .i_pins(i_chan_pins[g]),
            .o_out(chan_out[g]),
            .o_stop_evt(stop_evt[g]),
            .o_done_evt(done_evt[g])
        );
        // ------------------------------------------------------------
        // Checks
        // ------------------------------------------------------------
        logic [31:0] run_len;
        always_ff @(posedge i_clk) begin
            if (i_rst || !chan_out[g].cal_run) begin
                run_len <= 32'h0000_0000;
            end else begin
                run_len <= run_len + 32'h0000_0001;
            end
        end

        ref_route_a: assert property (@(posedge i_clk) disable iff (i_rst)
            ##1 chan_out[g].ref_ext == $past(fb_reg | cfg[g].ref_ext))
            else $error("reference source routing wrong");
        level_copy_a: assert property (@(posedge i_clk) disable iff (i_rst)
            ##1 chan_out[g].dac_level == $past(cfg[g].level))
            else $error("dimming level not copied");
        zero_stop_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (!fb_reg && !cfg[g].ref_ext && cfg[g].level == 8'h00)
            |=> !chan_out[g].switch_en)
            else $error("switching at zero level");
        fb_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (fb_reg && !(i_chan_pins[g].pulse_in
                         && i_enable_undervoltage_pin))
            |=> !chan_out[g].gate_en)
            else $error("fallback gate without both pins");
        ext_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
            ((fb_reg || cfg[g].ref_ext) && i_chan_pins[g].ext_low)
            |=> !chan_out[g].switch_en && !chan_out[g].soft_start)
            else $error("switching with low external reference");
        // stretch and forced mode are exclusive
        stretch_fccm_a: assert property (@(posedge i_clk) disable iff (i_rst)
            !(chan_out[g].stretch && chan_out[g].fccm))
            else $error("stretch overlaps forced continuous mode");
        // routine length
        // The run is counted in helper logic; a plain delay this long
        // would be far too costly for the tools.
        cal_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
            done_evt[g] |-> run_len == CAL_CYCLES)
            else $error("calibration length wrong");
        done_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
            done_evt[g] |-> chan_out[g].cal_done && !chan_out[g].cal_run)
            else $error("done flag missing on completion");
        start_inhib_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (start_reg[g] && !cfg[g].cal_en && !chan_out[g].cal_run)
            |=> !chan_out[g].cal_run)
            else $error("calibration started while disabled");
        gate_or_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (!fb_reg && (i_chan_pins[g].pulse_in || cfg[g].pwm_bit))
            |=> chan_out[g].gate_en)
            else $error("gate not enabled by dimming source");
        done_clr_a: assert property (@(posedge i_clk) disable iff (i_rst)
            (start_reg[g] && cfg[g].cal_en && !chan_out[g].cal_run)
            |=> chan_out[g].cal_run && !chan_out[g].cal_done)
            else $error("done flag not cleared on start");
        fb_ext_a: assert property (@(posedge i_clk) disable iff (i_rst)
            fb_reg |=> chan_out[g].ref_ext)
            else $error("fallback without external reference");
        fccm_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
            ((fb_reg || cfg[g].ref_ext) && i_chan_pins[g].over_range
             && !i_chan_pins[g].ss_released)
            |=> !chan_out[g].fccm)
            else $error("forced mode before soft-start release");
        offs_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
            !cfg[g].cal_en |=> chan_out[g].cal_offset == $past(calw_reg[g]))
            else $error("written offset not in use");
    end

    fb_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_fallback == $past(i_fallback_request_pin))
        else $error("fallback state not following pin");
endmodule // ladc_top

// *** sim/ladc_host.sv ***
// Model of the controller pins that face the dimming block.
// Assumes the bench gives pin wishes; they reach the block on i_clk edges.
// ----------------------------------------------------------------
// Pin model
// ----------------------------------------------------------------
module ladc_host (
    input wire logic i_clk,
    input wire ladc_pkg::ladc_pins_s [1:0] i_want,
    input wire logic i_cal_hold,
    input wire logic i_fb,
    input wire logic i_en,
    output ladc_pkg::ladc_pins_s [1:0] o_pins,
    output logic o_fb,
    output logic o_en
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_clk) begin
        o_pins <= i_want;
        // pulse held low
        // The output must carry no current while the routine measures.
        if (i_cal_hold) begin
            o_pins[0].pulse_in <= 1'h0;
            o_pins[1].pulse_in <= 1'h0;
        end
        o_fb <= i_fb;
        o_en <= i_en;
    end
endmodule // ladc_host

// *** sim/tb_top.sv ***
// Self-checking bench for the two-channel dimming block.
// Assumes a classic Wishbone port and a short calibration count.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CALN = 20;
    logic i_clk = 1'h0;
    logic i_rst = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rd_dat;
    logic [31:0] rdat;
    logic ack, fbk, irq, fb_pin, en_pin;
    logic fb_req = 1'h0;
    logic en_req = 1'h0;
    logic hold = 1'h0;
    ladc_pkg::ladc_pins_s [1:0] want = '0;
    ladc_pkg::ladc_pins_s [1:0] pins;
    ladc_pkg::ladc_out_s [1:0] ch;
    int n_errors = 0;
    int checks_done = 0;
    always #10 i_clk = ~i_clk;
    ladc_host host (.i_clk(i_clk), .i_want(want), .i_cal_hold(hold),
        .i_fb(fb_req), .i_en(en_req), .o_pins(pins), .o_fb(fb_pin),
        .o_en(en_pin));
    ladc_top #(.CAL_CYCLES(CALN)) dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rd_dat), .o_wb_ack(ack),
        .i_fallback_request_pin(fb_pin), .i_enable_undervoltage_pin(en_pin),
        .i_chan_pins(pins), .o_chan(ch), .o_fallback(fbk), .o_irq(irq));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Holds the request until ack is seen or 20 cycles pass, so no fixed latency is assumed.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h3;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'h1 && n < 20);
        if (n >= 20) n_errors++;
        rdat = rd_dat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        chk("read", rdat, e);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h20, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_internal;
        wb(1'h1, 8'h00, 32'h0000_0280);
        tick(3);
        chk("soft", ch[0].soft_start, 1'h1);
        chk("dac", ch[0].dac_level, 8'h80);
        chk("refx", ch[0].ref_ext, 1'h0);
        chk("gate", ch[0].gate_en, 1'h1);
        want[0].ss_released = 1'h1;
        tick(3);
        chk("switch", ch[0].switch_en, 1'h1);
        $display("internal test done");
    endtask
    task automatic t_zero;
        wb(1'h1, 8'h18, 32'h2);
        wb(1'h1, 8'h00, 32'h0000_0200);
        tick(3);
        chk("switch", ch[0].switch_en, 1'h0);
        chk("irq", irq, 1'h1);
        wb(1'h1, 8'h14, 32'h2);
        tick(2);
        chk("irq", irq, 1'h0);
        want[0].ss_released = 1'h0;
        wb(1'h1, 8'h00, 32'h0000_0210);
        tick(3);
        chk("soft", ch[0].soft_start, 1'h1);
        $display("zero test done");
    endtask
    task automatic t_ext;
        wb(1'h1, 8'h00, 32'h0000_0310);
        want[0].ext_low <= 1'h1;
        tick(4);
        chk("switch", ch[0].switch_en, 1'h0);
        chk("soft", ch[0].soft_start, 1'h0);
        want[0].ext_low = 1'h0;
        want[0].ext_high = 1'h1;
        want[0].over_range = 1'h1;
        tick(4);
        chk("soft", ch[0].soft_start, 1'h1);
        chk("refx", ch[0].ref_ext, 1'h1);
        chk("stretch", ch[0].stretch, 1'h1);
        chk("fccm", ch[0].fccm, 1'h0);
        want[0].ss_released = 1'h1;
        tick(4);
        chk("stretch", ch[0].stretch, 1'h0);
        chk("fccm", ch[0].fccm, 1'h1);
        $display("external test done");
    endtask
    task automatic t_fallback;
        fb_req = 1'h1;
        tick(4);
        chk("fb", fbk, 1'h1);
        chk("switch", ch[0].switch_en, 1'h0);
        want[0].pulse_in = 1'h1;
        tick(4);
        chk("switch", ch[0].switch_en, 1'h0);
        en_req = 1'h1;
        tick(4);
        chk("switch", ch[0].switch_en, 1'h1);
        wb(1'h1, 8'h00, 32'h0000_0200);
        tick(3);
        chk("refx", ch[0].ref_ext, 1'h1);
        chk("switch", ch[0].switch_en, 1'h1);
        fb_req = 1'h0;
        en_req = 1'h0;
        $display("fallback test done");
    endtask
    task automatic t_cal;
        int n;
        hold = 1'h1;
        want[0].cal_measured = 8'hA5;
        wb(1'h1, 8'h08, 32'h5A);
        wb(1'h1, 8'h00, 32'h0000_0800);
        tick(3);
        chk("run", ch[0].cal_run, 1'h0);
        chk("offs", ch[0].cal_offset, 8'h5A);
        rd(8'h08, 32'h5A);
        wb(1'h1, 8'h18, 32'h1);
        wb(1'h1, 8'h00, 32'h0000_0400);
        wb(1'h1, 8'h00, 32'h0000_0C00);
        n = 0;
        tick(1);
        while (ch[0].cal_run === 1'h1 && n < 100) begin
            n++;
            tick(1);
        end
        chk("length", n, CALN);
        chk("done", ch[0].cal_done, 1'h1);
        chk("offs", ch[0].cal_offset, 8'hA5);
        rd(8'h08, 32'hA5);
        tick(2);
        chk("irq", irq, 1'h1);
        wb(1'h1, 8'h00, 32'h0000_0C00);
        tick(1);
        chk("done", ch[0].cal_done, 1'h0);
        chk("run", ch[0].cal_run, 1'h1);
        wb(1'h1, 8'h00, 32'h0);
        tick(3);
        chk("offs", ch[0].cal_offset, 8'h5A);
        hold = 1'h0;
        $display("calibration test done");
    endtask
    // ----------------------------------------------------------------
    // Sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'h0;
        t_reset;
        t_internal;
        t_zero;
        t_ext;
        t_fallback;
        t_cal;
        stop_test;
    end
    // The tests need well under a thousand cycles; the margin is wide.
    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        stop_test;
    end
endmodule // tb_top
